// ### hdl/mpm_core.sv
// MDIO station manager, full-duplex pause timing, remote pause request and
// transmit error detection with an APB register file.
// Assumes the transmit and receive state machines share pclk; crs, col and
// mdio_i come from pins and are synchronised here.
//
// The APB slave port and the placing of the registers were chosen for this implementation.
module mpm_core #(
    parameter int unsigned MDC_HALF  = 4,
    parameter int unsigned DEFER_CYC = mpm_pkg::DEFER_CYC
) (
    // Clock and reset
    input  wire logic                clk_unused_tie,
    input  wire logic                pclk,
    input  wire logic                presetn,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Management link
    output logic                     mdc,
    input  wire logic                mdio_i,
    output logic                     mdio_o,
    output logic                     mdio_oe,
    // MII status pins
    input  wire logic                crs,
    input  wire logic                col,
    // Receive side
    input  wire mpm_pkg::mpm_rx_ctl_t rx_ctl,
    input  wire logic                rx_missed,
    output logic                     pause_hold,
    output logic                     pause_end,
    // Transmit side
    input  wire mpm_pkg::mpm_tx_ev_t tx_ev,
    output mpm_pkg::mpm_tx_res_t     tx_res,
    output logic                     send_pause_request,
    output logic [mpm_pkg::TXS_W-1:0] tx_frame_status,
    output logic                     tx_err_irq
);

    typedef struct packed {
        mpm_pkg::mpm_md_st_t      md_st;
        logic [7:0]               md_div;
        logic                     mdc;
        logic [6:0]               md_bit;
        logic [63:0]              md_frame;
        logic                     md_rd;
        logic                     mdio_o;
        logic                     mdio_oe;
        logic [15:0]              md_rdata;
        logic                     mdi_m;
        logic                     mdi_s;
        logic                     crs_m;
        logic                     crs_s;
        logic                     col_m;
        logic                     col_s;
        logic                     col_prev;
        logic                     pause_req;
        logic                     loopback;
        logic [mpm_pkg::TXS_W-1:0] tx_ien;
        logic [mpm_pkg::TXS_W-1:0] tx_stat;
        logic [mpm_pkg::TXS_W-1:0] cf_stat;
        logic [mpm_pkg::TXS_W-1:0] fr_stat;
        logic [15:0]              missed;
        logic [15:0]              pause_cnt;
        logic [10:0]              quanta;
        logic                     pause_end;
        logic                     tx_active;
        logic [4:0]               attempts;
        logic [6:0]               byte_cnt;
        logic                     crs_seen;
        logic                     crs_mon;
        logic                     first_att;
        logic [16:0]              defer_cnt;
        mpm_pkg::mpm_tx_res_t     res;
    } mpm_state_t;

    localparam logic [7:0]  MDC_LAST   = 8'(MDC_HALF - 1);
    localparam logic [10:0] QUANT_LAST = 11'(mpm_pkg::QUANTUM_CYC - 1);
    localparam logic [16:0] DEFER_LAST = 17'(DEFER_CYC - 1);

    mpm_state_t s_q;
    mpm_state_t s_d;

    logic                      wr;
    logic                      rd_ok;
    logic                      recog;
    logic                      col_rise;
    logic                      par_bad;
    logic                      end_frame;
    logic [4:0]                att_n;
    logic [mpm_pkg::TXS_W-1:0] ev;

    assign wr = psel && penable && pwrite;

    ////////////////////////////////////////////////////////////////////////////
    // APB read side, zero wait states
    always_comb begin
        rd_ok  = 1'b1;
        prdata = 32'h0000_0000;
        case (paddr)
            mpm_pkg::A_CTRL: begin
                prdata[mpm_pkg::CTRL_SEND_PAUSE] = s_q.pause_req;
                prdata[mpm_pkg::CTRL_LOOPBACK]   = s_q.loopback;
            end
            mpm_pkg::A_TXIEN:  prdata[mpm_pkg::TXS_W-1:0] = s_q.tx_ien;
            mpm_pkg::A_TXSTAT: prdata[mpm_pkg::TXS_W-1:0] = s_q.tx_stat;
            mpm_pkg::A_CFSTAT: prdata[mpm_pkg::TXS_W-1:0] = s_q.cf_stat;
            mpm_pkg::A_MDCMD:  prdata = 32'h0000_0000;
            mpm_pkg::A_MDSTAT: begin
                prdata[15:0]                 = s_q.md_rdata;
                prdata[mpm_pkg::MDSTAT_BUSY] = (s_q.md_st == mpm_pkg::MD_RUN);
            end
            mpm_pkg::A_PAUSE:  prdata[15:0] = s_q.pause_cnt;
            mpm_pkg::A_MISSED: prdata[15:0] = s_q.missed;
            default:           rd_ok = 1'b0;
        endcase
    end

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !rd_ok;

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        s_d = s_q;
        recog = rx_ctl.valid && rx_ctl.addr_hit
            && (rx_ctl.len_type == mpm_pkg::PAUSE_TYPE)
            && (rx_ctl.length == mpm_pkg::PAUSE_LEN)
            && (rx_ctl.opcode == mpm_pkg::PAUSE_OPCODE);
        col_rise  = s_q.col_s && !s_q.col_prev;
        par_bad   = (^{tx_ev.fifo_data, tx_ev.fifo_par}) != mpm_pkg::PAR_ODD;
        att_n     = s_q.attempts + 5'h01;
        ev        = '0;
        end_frame = 1'b0;

        s_d.mdi_m    = mdio_i;
        s_d.mdi_s    = s_q.mdi_m;
        s_d.crs_m    = crs;
        s_d.crs_s    = s_q.crs_m;
        s_d.col_m    = col;
        s_d.col_s    = s_q.col_m;
        s_d.col_prev = s_q.col_s;
        s_d.res       = '0;
        s_d.pause_end = 1'b0;

        // Software writes
        if (wr) begin
            case (paddr)
                mpm_pkg::A_CTRL: begin
                    s_d.pause_req = pwdata[mpm_pkg::CTRL_SEND_PAUSE];
                    s_d.loopback  = pwdata[mpm_pkg::CTRL_LOOPBACK];
                end
                mpm_pkg::A_TXIEN:  s_d.tx_ien  = pwdata[mpm_pkg::TXS_W-1:0];
                mpm_pkg::A_TXSTAT: s_d.tx_stat = s_q.tx_stat & ~pwdata[mpm_pkg::TXS_W-1:0];
                mpm_pkg::A_MDCMD: begin
                    if (s_q.md_st == mpm_pkg::MD_IDLE) begin
                        s_d.md_st    = mpm_pkg::MD_RUN;
                        s_d.md_rd    = pwdata[mpm_pkg::MDCMD_READ];
                        s_d.md_frame = {mpm_pkg::MD_PREAMBLE, mpm_pkg::MD_SOF,
                            pwdata[mpm_pkg::MDCMD_READ] ? mpm_pkg::MD_OP_RD : mpm_pkg::MD_OP_WR,
                            pwdata[mpm_pkg::MDCMD_PHY_LSB +: 5],
                            pwdata[mpm_pkg::MDCMD_REG_LSB +: 5],
                            mpm_pkg::MD_TA_WR,
                            pwdata[mpm_pkg::MDCMD_DATA_LSB +: 16]};
                        s_d.md_bit   = 7'h00;
                        s_d.md_div   = 8'h00;
                        s_d.mdc      = 1'b0;
                        s_d.mdio_o   = 1'b1;
                        s_d.mdio_oe  = 1'b1;
                    end
                end
                default: ;
            endcase
        end

        ////////////////////////////////////////////////////////////////////////
        // Management frame engine: bits change after MDC falls, sampled on rise
        if (s_q.md_st == mpm_pkg::MD_RUN) begin
            if (s_q.md_div == MDC_LAST) begin
                s_d.md_div = 8'h00;
                s_d.mdc    = !s_q.mdc;
                if (!s_q.mdc) begin
                    if (s_q.md_rd && s_q.md_bit >= mpm_pkg::MD_BIT_DATA
                        && s_q.md_bit < mpm_pkg::MD_BIT_IDLE) begin
                        s_d.md_rdata = {s_q.md_rdata[14:0], s_q.mdi_s};
                    end
                end else begin
                    s_d.md_bit = s_q.md_bit + 7'h01;
                    s_d.mdio_o = s_q.md_frame[6'(7'h3F - (s_q.md_bit + 7'h01))];
                    if (s_q.md_bit + 7'h01 >= mpm_pkg::MD_BIT_IDLE) begin
                        s_d.mdio_oe = 1'b0;
                        s_d.mdio_o  = 1'b0;
                    end else if (s_q.md_rd && s_q.md_bit + 7'h01 >= mpm_pkg::MD_BIT_TA) begin
                        s_d.mdio_oe = 1'b0;
                        s_d.mdio_o  = 1'b0;
                    end
                    if (s_q.md_bit + 7'h01 == mpm_pkg::MD_BIT_END) begin
                        s_d.md_st = mpm_pkg::MD_IDLE;
                    end
                end
            end else begin
                s_d.md_div = s_q.md_div + 8'h01;
            end
        end

        ////////////////////////////////////////////////////////////////////////
        // Pause counter
        if (recog) begin
            s_d.pause_cnt = rx_ctl.operand;
            s_d.quanta    = 11'h000;
            s_d.pause_end = (rx_ctl.operand == 16'h0000) && (s_q.pause_cnt != 16'h0000);
        end else if (s_q.pause_cnt != 16'h0000) begin
            if (s_q.quanta == QUANT_LAST) begin
                s_d.quanta    = 11'h000;
                s_d.pause_cnt = s_q.pause_cnt - 16'h0001;
                s_d.pause_end = (s_q.pause_cnt == 16'h0001);
            end else begin
                s_d.quanta = s_q.quanta + 11'h001;
            end
        end

        if (rx_missed && s_q.missed != 16'hFFFF) begin
            s_d.missed = s_q.missed + 16'h0001;
        end

        ////////////////////////////////////////////////////////////////////////
        // Transmit error tracking
        if (tx_ev.attempt_start) begin
            s_d.tx_active = 1'b1;
            s_d.attempts  = 5'h00;
            s_d.first_att = 1'b1;
            s_d.defer_cnt = 17'h00000;
            s_d.fr_stat   = '0;
        end else if (s_q.tx_active) begin
            if (tx_ev.pre_start) begin
                s_d.byte_cnt = 7'h00;
                s_d.crs_seen = 1'b0;
                s_d.crs_mon  = 1'b0;
            end
            // Carrier is watched from the delimiter until the frame ends
            if (tx_ev.sfd) begin
                s_d.crs_mon = 1'b1;
            end
            if (tx_ev.byte_sent && s_q.byte_cnt != 7'h7F) begin
                s_d.byte_cnt = s_q.byte_cnt + 7'h01;
            end
            if ((tx_ev.sfd || s_q.crs_mon) && s_q.crs_s) begin
                s_d.crs_seen = 1'b1;
            end
            if (s_q.first_att && tx_ev.defer) begin
                s_d.defer_cnt = s_q.defer_cnt + 17'h00001;
                if (s_q.defer_cnt == DEFER_LAST) begin
                    ev[mpm_pkg::TXS_EXDEF] = 1'b1;
                end
            end
            if (tx_ev.fifo_rd && tx_ev.fifo_empty) begin
                ev[mpm_pkg::TXS_UNDER] = 1'b1;
            end else if (tx_ev.fifo_rd && par_bad) begin
                ev[mpm_pkg::TXS_PARITY] = 1'b1;
            end
            if (col_rise) begin
                s_d.attempts  = att_n;
                s_d.first_att = 1'b0;
                if (att_n == mpm_pkg::MAX_ATTEMPTS) begin
                    ev[mpm_pkg::TXS_EXCOL] = 1'b1;
                end else begin
                    s_d.res.backoff = 1'b1;
                    if (s_q.byte_cnt >= mpm_pkg::LATE_BYTES) begin
                        ev[mpm_pkg::TXS_LATE] = 1'b1;
                    end
                end
            end
            if (ev[mpm_pkg::TXS_EXDEF] || ev[mpm_pkg::TXS_UNDER]
                || ev[mpm_pkg::TXS_PARITY] || ev[mpm_pkg::TXS_EXCOL]) begin
                s_d.res.abort = 1'b1;
                end_frame     = 1'b1;
            end else if (tx_ev.frame_end && !col_rise) begin
                ev[mpm_pkg::TXS_OK]    = 1'b1;
                ev[mpm_pkg::TXS_NOCRS] = !s_q.crs_seen && !s_q.crs_s && !s_q.loopback;
                s_d.res.done_ok        = 1'b1;
                end_frame              = 1'b1;
            end
        end

        s_d.tx_stat = s_d.tx_stat | ev;
        s_d.fr_stat = s_d.fr_stat | ev;
        if (end_frame) begin
            s_d.tx_active       = 1'b0;
            s_d.attempts        = 5'h00;
            s_d.res.stat_strobe = 1'b1;
            if (tx_ev.ctl_frame) begin
                s_d.cf_stat = s_q.fr_stat | ev;
                if (!(wr && paddr == mpm_pkg::A_CTRL)) begin
                    s_d.pause_req = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q       <= '0;
            s_q.md_st <= mpm_pkg::MD_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign mdc                = s_q.mdc;
    assign mdio_o             = s_q.mdio_o;
    assign mdio_oe            = s_q.mdio_oe;
    assign pause_hold         = (s_q.pause_cnt != 16'h0000);
    assign pause_end          = s_q.pause_end;
    assign tx_res             = s_q.res;
    assign send_pause_request = s_q.pause_req;
    assign tx_frame_status    = s_q.fr_stat;
    assign tx_err_irq         = |(s_q.tx_stat & s_q.tx_ien);

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_wr_ta;
        s_q.mdio_oe && s_q.mdio_o;
    endsequence

    property p_preamble;
        s_q.md_st == mpm_pkg::MD_RUN && s_q.md_bit < mpm_pkg::MD_BIT_PRE |-> s_q.mdio_oe && s_q.mdio_o;
    endproperty
    a_preamble: assert property (p_preamble) else $error("preamble bit not one");

    property p_write_ta;
        s_q.md_st == mpm_pkg::MD_RUN && !s_q.md_rd && s_q.md_bit == mpm_pkg::MD_BIT_TA |-> s_wr_ta;
    endproperty
    a_write_ta: assert property (p_write_ta) else $error("write turnaround wrong");

    property p_read_release;
        s_q.md_st == mpm_pkg::MD_RUN && s_q.md_rd && s_q.md_bit >= mpm_pkg::MD_BIT_TA |-> !s_q.mdio_oe;
    endproperty
    a_read_release: assert property (p_read_release) else $error("read line not released");

    property p_busy_hold;
        s_q.md_st == mpm_pkg::MD_RUN && wr && paddr == mpm_pkg::A_MDCMD |=> $stable(s_q.md_frame);
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("command taken while busy");

    property p_pause_load;
        recog |=> s_q.pause_cnt == $past(rx_ctl.operand) && (pause_hold == (s_q.pause_cnt != 16'h0000));
    endproperty
    a_pause_load: assert property (p_pause_load) else $error("pause operand not loaded");

    property p_pause_dec;
        !recog && pause_hold && s_q.quanta == QUANT_LAST |=> s_q.pause_cnt == $past(s_q.pause_cnt) - 16'h0001;
    endproperty
    a_pause_dec: assert property (p_pause_dec) else $error("pause count not decremented");

    property p_parity_abort;
        s_q.tx_active && !tx_ev.attempt_start && tx_ev.fifo_rd && !tx_ev.fifo_empty && par_bad
            |=> tx_res.abort && s_q.tx_stat[mpm_pkg::TXS_PARITY];
    endproperty
    a_parity_abort: assert property (p_parity_abort) else $error("parity error did not abort");

    property p_underrun_abort;
        s_q.tx_active && !tx_ev.attempt_start && tx_ev.fifo_rd && tx_ev.fifo_empty
            |=> tx_res.abort && s_q.tx_stat[mpm_pkg::TXS_UNDER];
    endproperty
    a_underrun_abort: assert property (p_underrun_abort) else $error("underrun did not abort");

    property p_excol;
        s_q.tx_active && !tx_ev.attempt_start && col_rise && s_q.attempts == 5'h0F
            |=> tx_res.abort && !tx_res.backoff && s_q.tx_stat[mpm_pkg::TXS_EXCOL];
    endproperty
    a_excol: assert property (p_excol) else $error("sixteenth collision did not abort");

endmodule

// ### hdl/mpm_pkg.sv
// Constants, register map and carrier types for the MAC pause, MDIO and tx error block.
// Assumes a 20 MHz APB clock and a 10 Mbit/s bit time.
package mpm_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_TXIEN  = 8'h04;
    localparam logic [7:0] A_TXSTAT = 8'h08;
    localparam logic [7:0] A_CFSTAT = 8'h0C;
    localparam logic [7:0] A_MDCMD  = 8'h10;
    localparam logic [7:0] A_MDSTAT = 8'h14;
    localparam logic [7:0] A_PAUSE  = 8'h18;
    localparam logic [7:0] A_MISSED = 8'h1C;

    // Control fields
    localparam int CTRL_SEND_PAUSE = 0;
    localparam int CTRL_LOOPBACK   = 1;
    // Management command and status fields
    localparam int MDCMD_DATA_LSB  = 0;
    localparam int MDCMD_REG_LSB   = 16;
    localparam int MDCMD_PHY_LSB   = 21;
    localparam int MDCMD_READ      = 26;
    localparam int MDSTAT_BUSY     = 31;

    // Transmit status bits
    localparam int TXS_W      = 7;
    localparam int TXS_PARITY = 0;
    localparam int TXS_UNDER  = 1;
    localparam int TXS_NOCRS  = 2;
    localparam int TXS_EXCOL  = 3;
    localparam int TXS_LATE   = 4;
    localparam int TXS_EXDEF  = 5;
    localparam int TXS_OK     = 6;

    ////////////////////////////////////////////////////////////////////////////
    // Management frame layout
    localparam logic [31:0] MD_PREAMBLE = 32'hFFFF_FFFF;
    localparam logic [1:0]  MD_SOF      = 2'h1;
    localparam logic [1:0]  MD_OP_WR    = 2'h1;
    localparam logic [1:0]  MD_OP_RD    = 2'h2;
    localparam logic [1:0]  MD_TA_WR    = 2'h2;
    localparam logic [6:0]  MD_BIT_PRE  = 7'h20;
    localparam logic [6:0]  MD_BIT_TA   = 7'h2E;
    localparam logic [6:0]  MD_BIT_DATA = 7'h30;
    localparam logic [6:0]  MD_BIT_IDLE = 7'h40;
    localparam logic [6:0]  MD_BIT_END  = 7'h41;

    typedef enum logic [0:0] {
        MD_IDLE = 1'b0,
        MD_RUN  = 1'b1
    } mpm_md_st_t;

    ////////////////////////////////////////////////////////////////////////////
    // Pause recognition and timing
    localparam logic [15:0] PAUSE_TYPE   = 16'h8808;
    localparam logic [15:0] PAUSE_OPCODE = 16'h0001;
    localparam logic [10:0] PAUSE_LEN    = 11'h040;
    localparam int CLK_NS         = 50;
    localparam int BIT_NS         = 100;
    localparam int QUANTUM_BITS   = 512;
    localparam int QUANTUM_CYC    = QUANTUM_BITS * BIT_NS / CLK_NS;
    localparam int DEFER_BITS     = 32768;
    localparam int DEFER_CYC      = DEFER_BITS * BIT_NS / CLK_NS;

    // Transmit limits
    localparam logic [6:0] LATE_BYTES   = 7'h40;
    localparam logic [4:0] MAX_ATTEMPTS = 5'h10;
    localparam logic       PAR_ODD      = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic        valid;
        logic [15:0] len_type;
        logic        addr_hit;
        logic [10:0] length;
        logic [15:0] opcode;
        logic [15:0] operand;
    } mpm_rx_ctl_t;

    typedef struct packed {
        logic       attempt_start;
        logic       defer;
        logic       pre_start;
        logic       sfd;
        logic       byte_sent;
        logic       fifo_rd;
        logic [7:0] fifo_data;
        logic       fifo_par;
        logic       fifo_empty;
        logic       frame_end;
        logic       ctl_frame;
    } mpm_tx_ev_t;

    typedef struct packed {
        logic abort;
        logic done_ok;
        logic backoff;
        logic stat_strobe;
    } mpm_tx_res_t;

endpackage

// ### verif/mpm_phy_model.sv
// PHY partner: shifts in every management bit, answers read frames.
// Assumes mdc idles low and each frame lasts 65 mdc periods.
module mpm_phy_model (
    input  wire logic        mdc,
    input  wire logic        mdio_o,
    input  wire logic        mdio_oe,
    output logic             mdio,
    input  wire logic [15:0] reg_val,
    output logic [63:0]      frm
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:0] cnt = 7'h00;
    logic       drv = 1'b0;
    logic       dat = 1'b1;
    // Pull-up holds the released line high
    assign mdio = mdio_oe ? mdio_o : (drv ? dat : 1'b1);
    always @(posedge mdc) begin
        frm <= {frm[62:0], mdio};
        cnt <= (cnt == 7'h40) ? 7'h00 : cnt + 7'h01;
    end
    // Zero then data MSB first, changed after mdc falls
    always @(negedge mdc) begin
        drv <= (cnt == 7'h2F) ? (frm[12:11] == 2'b10) : (drv && cnt < 7'h40);
        dat <= (cnt == 7'h2F) ? 1'b0 : reg_val[~cnt[3:0]];
    end
endmodule

// ### verif/tb_mpm_core.sv
// Bench for mpm_core: APB master, PHY partner, pause and transmit events.
// Assumes mpm_phy_model on the management line and a shortened defer count.
module tb_mpm_core;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic crs = 1'b0, col = 1'b0, rx_missed = 1'b0, pready, pslverr, serr;
    logic mdc, mdio, mdio_o, mdio_oe, pause_hold, pause_end, spr, irq;
    logic [7:0] paddr = 8'h00;
    logic [15:0] reg_val = 16'h0000;
    logic [31:0] pwdata = 32'h0, prdata, r, seed = 32'h0000004F;
    logic [63:0] frm;
    logic [6:0] tfs;
    mpm_pkg::mpm_rx_ctl_t rx_ctl = '0;
    mpm_pkg::mpm_tx_ev_t tx_ev = '0;
    mpm_pkg::mpm_tx_res_t tx_res, rs;
    int num_errors = 0, checks = 0, n;
    mpm_core #(.MDC_HALF(4), .DEFER_CYC(64)) uut (.clk_unused_tie(1'b0), .pclk, .presetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mdc,
        .mdio_i(mdio), .mdio_o, .mdio_oe, .crs, .col, .rx_ctl, .rx_missed, .pause_hold,
        .pause_end, .tx_ev, .tx_res, .send_pause_request(spr), .tx_frame_status(tfs),
        .tx_err_irq(irq));
    mpm_phy_model phy (.mdc, .mdio_o, .mdio_oe, .mdio, .reg_val, .frm);
    always #25 pclk = ~pclk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    task automatic chk(input string s, input logic [63:0] e, v);
        checks++;
        if (e !== v) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", s, e, v);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {r, serr, psel, penable} <= {prdata, pslverr, 2'b00};
        @(posedge pclk);
    endtask
    task automatic md(input logic rd);
        logic [4:0] ph, rg;
        logic [15:0] d;
        seed = xs(seed);
        {ph, rg, d} = seed[25:0];
        reg_val <= seed[31:16];
        apb(1'b1, mpm_pkg::A_MDCMD, {5'h00, rd, ph, rg, d});
        apb(1'b1, mpm_pkg::A_MDCMD, {5'h00, ~rd, ~ph, ~rg, ~d});
        apb(1'b0, mpm_pkg::A_MDSTAT, 32'h0);
        chk("busy", 1, r[31]);
        for (n = 0; n < 300 && r[31] !== 1'b0; n++) apb(1'b0, mpm_pkg::A_MDSTAT, 32'h0);
        chk("frame", {31'h7FFFFFFF, 2'b01, rd ? 2'b10 : 2'b01, ph, rg, 2'b10,
            rd ? reg_val : d, 1'b1}, frm);
        if (rd) chk("rdata", reg_val, r[15:0]);
    endtask
    task automatic px(input logic [10:0] len, input logic [15:0] op);
        rx_ctl <= '{1'b1, mpm_pkg::PAUSE_TYPE, 1'b1, len, mpm_pkg::PAUSE_OPCODE, op};
        @(posedge pclk) rx_ctl.valid <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask
    task automatic ev(input mpm_pkg::mpm_tx_ev_t e);
        tx_ev <= e;
        @(posedge pclk) tx_ev <= '0;
        #1 rs = tx_res;
        @(posedge pclk);
    endtask
    task automatic final_report;
        if (num_errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        md(1'b0);
        md(1'b1);
        px(mpm_pkg::PAUSE_LEN, 16'h0002);
        chk("hold", 1, pause_hold);
        apb(1'b0, mpm_pkg::A_PAUSE, 32'h0);
        chk("pcount", 2, r[15:0]);
        px(11'h041, 16'h0000);
        chk("hold", 1, pause_hold);
        px(mpm_pkg::PAUSE_LEN, 16'h0000);
        chk("hold", 0, pause_hold);
        px(mpm_pkg::PAUSE_LEN, 16'h0001);
        for (n = 0; n < 2000 && pause_end !== 1'b1; n++) @(posedge pclk);
        chk("pwait", 1, n > 1000 && n < 2000);
        apb(1'b1, mpm_pkg::A_TXIEN, 32'h3);
        for (int k = 0; k < 3; k++) begin
            seed = xs(seed);
            ev(18'h20000);
            ev(18'h08000);
            ev(18'h04000);
            ev(k == 2 ? 18'h00002 : {6'h01, seed[7:0], k[0] ? ~^seed[7:0] : ^seed[7:0],
                k[0], 2'b00});
            chk("result", k == 2 ? 4'h5 : 4'h9, rs & 4'hD);
            apb(1'b0, mpm_pkg::A_TXSTAT, 32'h0);
            chk("txstat", k == 2 ? 7'h44 : 7'h01 << k, r[6:0]);
            chk("irq", k != 2, irq);
            apb(1'b1, mpm_pkg::A_TXSTAT, 32'h7F);
        end
        apb(1'b1, mpm_pkg::A_CTRL, 32'h1);
        chk("spr", 1, spr);
        ev(18'h20000);
        ev(18'h08000);
        ev(18'h04000);
        crs <= 1'b1;
        repeat (3) @(posedge pclk);
        crs <= 1'b0;
        repeat (3) @(posedge pclk);
        ev(18'h00003);
        chk("spr", 0, spr);
        chk("frstat", 7'h40, tfs);
        apb(1'b0, mpm_pkg::A_CFSTAT, 32'h0);
        chk("cfstat", 7'h40, r[6:0]);
        apb(1'b1, mpm_pkg::A_CTRL, 32'h2);
        ev(18'h20000);
        ev(18'h08000);
        ev(18'h04000);
        ev(18'h00002);
        chk("loopback", 7'h40, tfs);
        ev(18'h20000);
        ev(18'h08000);
        tx_ev <= 18'h02000;
        repeat (64) @(posedge pclk);
        tx_ev <= '0;
        for (int k = 0; k < 16; k++) begin
            col <= 1'b1;
            repeat (2) @(posedge pclk);
            col <= 1'b0;
            repeat (2) @(posedge pclk);
        end
        chk("collide", 7'h18, tfs);
        ev(18'h20000);
        tx_ev <= 18'h10000;
        repeat (70) @(posedge pclk);
        tx_ev <= '0;
        @(posedge pclk);
        chk("defer", 7'h20, tfs);
        rx_missed <= 1'b1;
        repeat (3) @(posedge pclk);
        rx_missed <= 1'b0;
        apb(1'b0, mpm_pkg::A_MISSED, 32'h0);
        chk("missed", 3, r[15:0]);
        apb(1'b0, 8'h20, 32'h0);
        chk("slverr", 1, serr);
        final_report();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        final_report();
    end
endmodule
